// ==== hdl/sfps_pkg.sv ====
// constants for the serial flash program and status sequencer
// assumes a 200 MHz core clock that oversamples every pin of the serial link
package sfps_pkg;
  // opcodes
  localparam logic [7:0] OPC_BUF_WRITE = 8'h84;
  localparam logic [7:0] OPC_PROG_ERASE = 8'h83;
  localparam logic [7:0] OPC_PROG_ONLY = 8'h88;
  localparam logic [7:0] OPC_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OPC_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h82;
  localparam logic [7:0] OPC_REWRITE = 8'h58;
  localparam logic [7:0] OPC_STATUS = 8'h57;
  localparam logic [7:0] OPC_XFER = 8'h53;
  localparam logic [7:0] OPC_COMPARE = 8'h60;
  // array geometry
  localparam int PAGE_COUNT = 512;
  localparam int PAGE_BYTES = 264;
  localparam int MEM_BYTES = PAGE_COUNT * PAGE_BYTES;
  localparam logic [8:0] BUF_LAST = 9'h107;
  localparam logic [11:0] PAGE_LAST = 12'h107;
  localparam logic [11:0] BLOCK_LAST = 12'h83F;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  // command framing and address fields
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] HDR_LAST_BIT = 6'h1F;
  localparam logic [5:0] HDR_BITS = 6'h20;
  localparam int PAGE_LSB = 9;
  localparam int BYTE_LSB = 0;
  localparam int PROT_PAGE_BIT = 8;
  // status byte
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_CMP_BIT = 6;
  localparam logic [2:0] DENSITY_CODE = 3'h5; // value is arbitrary
  localparam logic [2:0] STAT_RSVD = 3'h0;
  localparam logic [2:0] STAT_FIRST_IDX = 3'h7;
  // synchroniser reset level {reset_n, wp_n, cs_n, sck, si}
  localparam logic [4:0] SYNC_RST = 5'h1E;
  // data fifo {buffer address, byte}
  localparam int FIFO_WIDTH = 17;
  localparam int FIFO_DEPTH = 16;
  // self-timed operation limits
  localparam int CLK_MHZ = 200;
  localparam int T_XFR_US = 200;
  localparam int T_EP_MS = 20;
  localparam int T_P_MS = 15;
  localparam int T_PE_MS = 10;
  localparam int T_BE_MS = 15;
  localparam int XFR_CYC = T_XFR_US * CLK_MHZ;
  localparam int EP_CYC = T_EP_MS * 1000 * CLK_MHZ;
  localparam int P_CYC = T_P_MS * 1000 * CLK_MHZ;
  localparam int PE_CYC = T_PE_MS * 1000 * CLK_MHZ;
  localparam int BE_CYC = T_BE_MS * 1000 * CLK_MHZ;
  typedef enum logic [2:0] {OPK_XFER, OPK_CMP, OPK_PROG_E, OPK_PROG, OPK_ERASE, OPK_BLOCK, OPK_REWRITE} sfps_op_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_WAIT} sfps_eng_t;
endpackage

// ==== hdl/sfps_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module sfps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // full and empty come straight from the fill count
  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_data = mem[rd_ptr];
  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // pointers wrap over the power-of-two depth
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // occupancy
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= '0;
    end else if (push && !pop) begin
      count <= count + (AW+1)'(1);
    end else if (pop && !push) begin
      count <= count - (AW+1)'(1);
    end
  end
endmodule // sfps_fifo
`default_nettype wire

// ==== hdl/sfps_flash_core.sv ====
// serial flash device core: command decode, buffer, array, self-timed program/erase, status
// assumes all pins are asynchronous to i_clk and the serial clock is far slower than i_clk
`timescale 1ns/100ps
`default_nettype none
module sfps_flash_core #(
  parameter int P_XFR_CYC = sfps_pkg::XFR_CYC,
  parameter int P_EP_CYC = sfps_pkg::EP_CYC,
  parameter int P_P_CYC = sfps_pkg::P_CYC,
  parameter int P_PE_CYC = sfps_pkg::PE_CYC,
  parameter int P_BE_CYC = sfps_pkg::BE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_write_guard_n,
  input wire logic i_reset_n,
  output logic o_so,
  output logic o_so_oe,
  output logic o_ready_busy_n,
  output logic o_ready_busy_n_oe
);
  import sfps_pkg::*;

  logic [4:0] sync_a, sync_b;
  logic reset_n_s, guard_n_s, cs_n_s, sck_s, si_s;
  logic rst_all, cs_n_d, sck_d, cs_fall, cs_rise, sck_rise, sck_fall;
  logic spi_mode3, skip_fall, fall_ok;
  logic [23:0] shift_in;
  logic [5:0] bit_cnt;
  logic [7:0] opcode, next_opcode;
  logic [23:0] next_hdr;
  logic [8:0] page_addr, wr_addr;
  logic hdr_done, status_mode;
  logic [2:0] data_bits;
  logic loads_buffer;
  logic push_valid;
  logic [FIFO_WIDTH-1:0] push_data;
  logic push_ready, drain_valid, drain_ready;
  logic [FIFO_WIDTH-1:0] drain_data;
  logic so_en;
  logic [2:0] so_idx;
  logic [7:0] status_byte;
  logic pending;
  sfps_op_t pend_kind;
  logic [8:0] pend_page;
  logic launch_ok;
  sfps_op_t launch_kind;
  logic guarded;
  sfps_eng_t eng;
  sfps_op_t kind;
  sfps_op_t act;
  logic pass2;
  logic [11:0] idx, idx_last;
  logic [17:0] base, mem_a;
  logic [8:0] buf_i;
  logic [31:0] timer, next_timer;
  logic cmp_diff, busy, start;
  logic [7:0] mem_rd, buf_rd;
  logic [7:0] mem [0:MEM_BYTES-1];
  logic [7:0] buffer [0:PAGE_BYTES-1];

  // two-flop synchronisers for every pin
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      sync_a <= {i_reset_n, i_write_guard_n, i_cs_n, i_sck, i_si};
      sync_b <= sync_a;
    end
  end
  assign {reset_n_s, guard_n_s, cs_n_s, sck_s, si_s} = sync_b;
  assign rst_all = i_rst | ~reset_n_s;

  // edge detection on synchronised chip select and clock
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b1;
    end else begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end
  assign cs_fall = cs_n_d & ~cs_n_s;
  assign cs_rise = ~cs_n_d & cs_n_s;
  assign sck_rise = ~sck_d & sck_s & ~cs_n_s;
  assign sck_fall = sck_d & ~sck_s & ~cs_n_s;
  assign fall_ok = sck_fall & ~skip_fall;

  // mode pick at chip select fall; mode 3 skips its leading falling edge
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      spi_mode3 <= 1'b1;
      skip_fall <= 1'b0;
    end else if (cs_fall) begin
      spi_mode3 <= sck_s;
      skip_fall <= sck_s;
    end else if (sck_fall) begin
      skip_fall <= 1'b0;
    end
  end

  assign next_opcode = {shift_in[6:0], si_s};
  assign next_hdr = {shift_in[22:0], si_s};
  assign loads_buffer = (opcode == OPC_BUF_WRITE) || (opcode == OPC_PAGE_PROG);

  // command shifter: opcode, then 24 address bits, then data
  always_ff @(posedge i_clk) begin
    if (rst_all || cs_fall) begin
      shift_in <= '0;
      bit_cnt <= '0;
      opcode <= '0;
      status_mode <= 1'b0;
      hdr_done <= 1'b0;
      page_addr <= '0;
      wr_addr <= '0;
      data_bits <= '0;
    end else if (sck_rise) begin
      shift_in <= next_hdr;
      if (bit_cnt != HDR_BITS) begin
        bit_cnt <= bit_cnt + 6'h01;
      end
      if (bit_cnt == OPC_LAST_BIT) begin
        opcode <= next_opcode;
        status_mode <= (next_opcode == OPC_STATUS);
      end
      if (bit_cnt == HDR_LAST_BIT) begin
        page_addr <= next_hdr[PAGE_LSB +: 9];
        wr_addr <= next_hdr[BYTE_LSB +: 9];
        hdr_done <= 1'b1;
      end
      if (hdr_done) begin
        data_bits <= data_bits + 3'h1;
        if ((data_bits == 3'h7) && loads_buffer) begin
          wr_addr <= (wr_addr == BUF_LAST) ? 9'h000 : wr_addr + 9'h001;
        end
      end
    end
  end

  // one byte per eight data clocks goes into the fifo, refused while busy
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      push_valid <= 1'b0;
      push_data <= '0;
    end else begin
      push_valid <= sck_rise && hdr_done && loads_buffer && (data_bits == 3'h7) && !busy;
      push_data <= {wr_addr, next_opcode};
    end
  end

  sfps_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_rst(rst_all),
    .i_valid(push_valid & push_ready),
    .o_ready(push_ready),
    .i_data(push_data),
    .o_valid(drain_valid),
    .i_ready(drain_ready),
    .o_data(drain_data)
  );
  // the buffer only takes fifo bytes while the engine leaves it alone
  assign drain_ready = (eng == ENG_IDLE);

  // live status byte
  assign status_byte = {~busy, cmp_diff, DENSITY_CODE, STAT_RSVD};

  // status shift-out position, first falling edge shows bit 7
  always_ff @(posedge i_clk) begin
    if (rst_all || cs_fall || cs_rise) begin
      so_en <= 1'b0;
      so_idx <= STAT_FIRST_IDX;
    end else if (fall_ok && status_mode) begin
      if (!so_en) begin
        so_en <= 1'b1;
      end else begin
        so_idx <= so_idx - 3'h1;
      end
    end
  end

  // output pin, refreshed every cycle from the live status
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else begin
      o_so <= so_en ? status_byte[so_idx] : 1'b0;
      o_so_oe <= so_en & ~cs_n_s & ~cs_rise;
    end
  end

  // operation chosen at chip select rise
  always_comb begin
    launch_ok = 1'b1;
    launch_kind = OPK_PROG_E;
    case (opcode)
      OPC_PROG_ERASE: launch_kind = OPK_PROG_E;
      OPC_PAGE_PROG: launch_kind = OPK_PROG_E;
      OPC_PROG_ONLY: launch_kind = OPK_PROG;
      OPC_PAGE_ERASE: launch_kind = OPK_ERASE;
      OPC_BLOCK_ERASE: launch_kind = OPK_BLOCK;
      OPC_REWRITE: launch_kind = OPK_REWRITE;
      OPC_XFER: launch_kind = OPK_XFER;
      OPC_COMPARE: launch_kind = OPK_CMP;
      default: launch_ok = 1'b0;
    endcase
  end
  // transfer and compare do not alter the array and are never guarded
  assign guarded = ~guard_n_s && ~page_addr[PROT_PAGE_BIT] && (launch_kind != OPK_XFER)
                   && (launch_kind != OPK_CMP);

  // pending launch waits for the fifo to finish filling the buffer
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      pending <= 1'b0;
      pend_kind <= OPK_PROG_E;
      pend_page <= '0;
    end else if (start) begin
      pending <= 1'b0;
    end else if (cs_rise && hdr_done && launch_ok && !guarded && !busy) begin
      pending <= 1'b1;
      pend_kind <= launch_kind;
      pend_page <= (launch_kind == OPK_BLOCK) ? {page_addr[8:3], 3'h0} : page_addr;
    end
  end
  assign start = pending && !drain_valid && (eng == ENG_IDLE);
  assign busy = pending || (eng != ENG_IDLE);

  // engine step kind; rewrite first copies, then programs with erase
  assign act = (kind == OPK_REWRITE) ? (pass2 ? OPK_PROG_E : OPK_XFER) : kind;
  assign idx_last = (kind == OPK_BLOCK) ? BLOCK_LAST : PAGE_LAST;
  assign mem_a = base + {6'h00, idx};
  assign buf_i = idx[8:0];
  assign mem_rd = mem[mem_a];
  assign buf_rd = buffer[buf_i];

  // cycle budget per operation
  always_comb begin
    next_timer = 32'(P_EP_CYC);
    case (pend_kind)
      OPK_XFER: next_timer = 32'(P_XFR_CYC);
      OPK_CMP: next_timer = 32'(P_XFR_CYC);
      OPK_PROG: next_timer = 32'(P_P_CYC);
      OPK_ERASE: next_timer = 32'(P_PE_CYC);
      OPK_BLOCK: next_timer = 32'(P_BE_CYC);
      default: next_timer = 32'(P_EP_CYC);
    endcase
  end

  // self-timed engine: one byte per cycle, then wait out the budget
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      eng <= ENG_IDLE;
      kind <= OPK_PROG_E;
      pass2 <= 1'b0;
      idx <= '0;
      base <= '0;
      timer <= '0;
    end else begin
      if (timer != 32'h0) begin
        timer <= timer - 32'h1;
      end
      case (eng)
        ENG_IDLE: begin
          if (start) begin
            eng <= ENG_RUN;
            kind <= pend_kind;
            pass2 <= 1'b0;
            idx <= '0;
            base <= {1'b0, pend_page, 8'h00} + {6'h00, pend_page, 3'h0};
            timer <= next_timer;
          end
        end
        ENG_RUN: begin
          if (idx == idx_last) begin
            idx <= '0;
            if ((kind == OPK_REWRITE) && !pass2) begin
              pass2 <= 1'b1;
            end else begin
              eng <= ENG_WAIT;
            end
          end else begin
            idx <= idx + 12'h001;
          end
        end
        ENG_WAIT: begin
          if (timer == 32'h0) begin
            eng <= ENG_IDLE;
          end
        end
        default: eng <= ENG_IDLE;
      endcase
    end
  end

  // main array writes
  always_ff @(posedge i_clk) begin
    if (eng == ENG_RUN) begin
      case (act)
        OPK_PROG_E: mem[mem_a] <= buf_rd;
        OPK_PROG: mem[mem_a] <= mem_rd & buf_rd;
        OPK_ERASE: mem[mem_a] <= ERASED_BYTE;
        OPK_BLOCK: mem[mem_a] <= ERASED_BYTE;
        default: ;
      endcase
    end
  end

  // buffer writes from the fifo or from a page copy
  always_ff @(posedge i_clk) begin
    if (drain_valid && drain_ready) begin
      buffer[drain_data[16:8]] <= drain_data[7:0];
    end else if ((eng == ENG_RUN) && (act == OPK_XFER)) begin
      buffer[buf_i] <= mem_rd;
    end
  end

  // compare result, cleared at compare start
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmp_diff <= 1'b0;
    end else if (start && (pend_kind == OPK_CMP)) begin
      cmp_diff <= 1'b0;
    end else if ((eng == ENG_RUN) && (act == OPK_CMP) && (mem_rd != buf_rd)) begin
      cmp_diff <= 1'b1;
    end
  end

  // open-drain ready/busy: enable pulls the pin low while busy
  always_ff @(posedge i_clk) begin
    if (rst_all) begin
      o_ready_busy_n <= 1'b0;
      o_ready_busy_n_oe <= 1'b0;
    end else begin
      o_ready_busy_n <= 1'b0;
      o_ready_busy_n_oe <= busy;
    end
  end
endmodule // sfps_flash_core
`default_nettype wire

// ==== test/sfps_host_model.sv ====
// host spi master model that drives the serial link of the flash core
// assumes the bench resolves the output pin and returns it on i_so
`timescale 1ns/100ps
`default_nettype none
module sfps_host_model (
  input wire logic i_so,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_si
);
  logic idle_hi;
  // deselected bus at power up, clock idles high
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b1;
    o_si = 1'b0;
    idle_hi = 1'b1;
  end
  // every command opens with a select fall, clock parked at the mode level
  task automatic sel(input logic m3);
    idle_hi = m3;
    o_sck = m3;
    #256;
    o_cs_n = 1'b0;
    #256;
  endtask
  // data set in the low phase, answer taken at the rise
  task automatic xbit(input logic b, output logic r);
    o_sck = 1'b0;
    o_si = b;
    #32;
    o_sck = 1'b1;
    r = i_so;
    #32;
  endtask
  // one byte, most significant bit first
  task automatic xb(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      xbit(b[i], r[i]);
    end
  endtask
  // close the frame; the data line stops showing the last bit
  task automatic desel();
    o_sck = idle_hi;
    #256;
    o_cs_n = 1'b1;
    o_si = ~o_si;
  endtask
endmodule // sfps_host_model
`default_nettype wire

// ==== test/sfps_flash_core_sva.sv ====
// pin level assertions for the flash core, bound to every instance
// assumes the bound core passes on its self-timed count parameters
`timescale 1ns/100ps
`default_nettype none
module sfps_flash_core_sva #(
  parameter int P_XFR_CYC = sfps_pkg::XFR_CYC,
  parameter int P_EP_CYC = sfps_pkg::EP_CYC,
  parameter int P_P_CYC = sfps_pkg::P_CYC,
  parameter int P_PE_CYC = sfps_pkg::PE_CYC,
  parameter int P_BE_CYC = sfps_pkg::BE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_cs_n,
  input wire logic i_sck,
  input wire logic i_si,
  input wire logic i_write_guard_n,
  input wire logic i_reset_n,
  input wire logic o_so,
  input wire logic o_so_oe,
  input wire logic o_ready_busy_n,
  input wire logic o_ready_busy_n_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  function automatic int mn(input int a, input int b);
    return (a < b) ? a : b;
  endfunction
  function automatic int mx(input int a, input int b);
    return (a > b) ? a : b;
  endfunction
  localparam int BUSY_MIN = mn(mn(P_XFR_CYC, P_P_CYC), mn(P_PE_CYC, mn(P_EP_CYC, P_BE_CYC)));
  localparam int BUSY_MAX = mx(mx(P_XFR_CYC, P_P_CYC), mx(P_PE_CYC, mx(P_EP_CYC, mx(P_BE_CYC, 2112)))) + 64;
  int busy_cnt;
  // length of the busy pulse so far
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_ready_busy_n_oe) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  a_so_idle: assert property (i_cs_n && $past(i_cs_n) && $past(i_cs_n, 2) && $past(i_cs_n, 3) |-> !o_so_oe)
    else $error("serial output driven while deselected");
  a_so_on_fall: assert property ($rose(o_so_oe) |-> !i_cs_n && !$past(i_sck))
    else $error("serial output enabled outside a clock low phase");
  a_rb_low_only: assert property (o_ready_busy_n_oe |-> !o_ready_busy_n)
    else $error("ready busy pin driven high");
  a_abort_idle: assert property (!i_reset_n && !$past(i_reset_n) && !$past(i_reset_n, 2) && !$past(i_reset_n, 3)
    && !$past(i_reset_n, 4) |-> !o_ready_busy_n_oe && !o_so_oe)
    else $error("activity while reset pin held low");
  a_busy_after_cs: assert property ($rose(o_ready_busy_n_oe) |-> i_cs_n && $past(i_cs_n, 3))
    else $error("busy began without a select rise");
  a_no_op_reset: assert property ($rose(o_ready_busy_n_oe) |-> i_reset_n && $past(i_reset_n, 4))
    else $error("operation started under reset pin");
  a_busy_min: assert property ($fell(o_ready_busy_n_oe) && i_reset_n |-> busy_cnt >= BUSY_MIN)
    else $error("busy pulse too short");
  a_busy_bounded: assert property (o_ready_busy_n_oe |-> busy_cnt <= BUSY_MAX)
    else $error("busy pulse too long");
endmodule // sfps_flash_core_sva
bind sfps_flash_core sfps_flash_core_sva #(.P_XFR_CYC(P_XFR_CYC), .P_EP_CYC(P_EP_CYC), .P_P_CYC(P_P_CYC),
  .P_PE_CYC(P_PE_CYC), .P_BE_CYC(P_BE_CYC)) sfps_flash_core_sva_inst (.i_clk(i_clk), .i_rst(i_rst),
  .i_cs_n(i_cs_n), .i_sck(i_sck), .i_si(i_si), .i_write_guard_n(i_write_guard_n), .i_reset_n(i_reset_n),
  .o_so(o_so), .o_so_oe(o_so_oe), .o_ready_busy_n(o_ready_busy_n), .o_ready_busy_n_oe(o_ready_busy_n_oe));
`default_nettype wire

// ==== test/sfps_flash_core_bench.sv ====
// self-checking bench for the flash program and status core
// assumes the host model drives the link and shortened self-timed counts
`timescale 1ns/100ps
`default_nettype none
module sfps_flash_core_bench;
  import sfps_pkg::*;
  localparam int XC = 600, EC = 1000, PC = 800, EEC = 700, BC = 3000;
  logic i_clk, i_rst, i_write_guard_n, i_reset_n;
  logic o_so, o_so_oe, o_ready_busy_n, o_ready_busy_n_oe, cs_n, sck, si;
  int error_cnt = 0, tests_run = 0, cyc = 0, n;
  logic [7:0] s, d;
  logic [8:0] pg;
  logic [7:0] ops [8] = '{OPC_PAGE_ERASE, OPC_PROG_ONLY, OPC_PROG_ERASE, OPC_BLOCK_ERASE, OPC_PAGE_PROG,
    OPC_REWRITE, OPC_XFER, OPC_COMPARE};
  int cy [8] = '{EEC, PC, EC, BC, EC, EC, XC, XC};
  // a released output toggles every half cycle so nothing stale is read
  wire so_pin = o_so_oe ? o_so : i_clk;
  // pull-up holds the released ready/busy pin high
  wire rb_pin = o_ready_busy_n_oe ? o_ready_busy_n : 1'b1;
  sfps_flash_core #(.P_XFR_CYC(XC), .P_EP_CYC(EC), .P_P_CYC(PC), .P_PE_CYC(EEC), .P_BE_CYC(BC))
    sfps_flash_core_inst (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
    .i_write_guard_n(i_write_guard_n), .i_reset_n(i_reset_n), .o_so(o_so), .o_so_oe(o_so_oe),
    .o_ready_busy_n(o_ready_busy_n), .o_ready_busy_n_oe(o_ready_busy_n_oe));
  sfps_host_model sfps_host_model_inst (.i_so(so_pin), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));
  // 200 MHz core clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 80000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // expected status byte from the ready state and the last compare result
  function automatic logic [7:0] exp_stat(input logic rdy, input logic diff);
    return {rdy, diff, DENSITY_CODE, STAT_RSVD};
  endfunction
  // opcode and 24 address bits in a random link mode
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    sfps_host_model_inst.sel(1'($urandom_range(1)));
    sfps_host_model_inst.xb(op, d);
    sfps_host_model_inst.xb(a[23:16], d);
    sfps_host_model_inst.xb(a[15:8], d);
    sfps_host_model_inst.xb(a[7:0], d);
  endtask
  // command, optional data bytes, then time the busy pulse
  task automatic run(input logic [7:0] op, input logic [23:0] a, input int exp, input int nb);
    cmd(op, a);
    for (int k = 0; k < nb; k++) begin
      sfps_host_model_inst.xb(k == 0 ? ERASED_BYTE : 8'(k - 1), d);
    end
    sfps_host_model_inst.desel();
    n = 0;
    repeat (exp + 200) begin
      @(negedge i_clk);
      n += (rb_pin === 1'b0) ? 1 : 0;
    end
    if (exp == 0) begin
      chk(n, 0);
    end else begin
      chk(32'(n >= exp && n <= exp + 16), 1);
    end
  endtask
  // status read of two passes
  task automatic stat(output logic [7:0] r);
    logic [7:0] r2;
    sfps_host_model_inst.sel(1'($urandom_range(1)));
    sfps_host_model_inst.xb(OPC_STATUS, d);
    sfps_host_model_inst.xb(8'h00, r);
    sfps_host_model_inst.xb(8'h00, r2);
    sfps_host_model_inst.desel();
    chk(r2, r);
  endtask
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_write_guard_n = 1'b1;
    i_reset_n = 1'b1;
    void'($urandom(18759));
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (8) @(negedge i_clk);
    chk(o_so_oe, 0);
    stat(s);
    chk({s[7], s[5:0]}, {1'b1, DENSITY_CODE, STAT_RSVD});
    // every array command on an unguarded page; erase precedes the plain program
    pg = 9'($urandom_range(511, 256));
    foreach (ops[i]) begin
      run(ops[i], i == 3 ? {6'h00, pg[8:3], 12'h000} : {6'h00, pg, 9'($urandom_range(263))}, cy[i], i == 4 ? 3 : 0);
    end
    // erased page copied to the buffer matches; a wrapped zero byte breaks it
    run(OPC_PAGE_ERASE, {6'h00, pg, 9'h000}, EEC, 0);
    run(OPC_XFER, {6'h00, pg, 9'h000}, XC, 0);
    run(OPC_COMPARE, {6'h00, pg, 9'h000}, XC, 0);
    stat(s);
    chk(s[6], 0);
    run(OPC_BUF_WRITE, {15'($urandom), BUF_LAST}, 0, 2);
    run(OPC_COMPARE, {6'h00, pg, 9'h000}, XC, 0);
    stat(s);
    chk(s[6], 1);
    // a page programmed from the buffer compares equal to it
    run(OPC_PROG_ERASE, {6'h00, pg, 9'h000}, EC, 0);
    run(OPC_COMPARE, {6'h00, pg, 9'h000}, XC, 0);
    stat(s);
    chk(s, exp_stat(1'b1, 1'b0));
    // guarded low pages refused, block number from upper page bits
    @(negedge i_clk);
    i_write_guard_n = 1'b0;
    run(OPC_PAGE_ERASE, {6'h00, 9'($urandom_range(255)), 9'h000}, 0, 0);
    run(OPC_PAGE_ERASE, {6'h00, pg, 9'h000}, EEC, 0);
    run(OPC_BLOCK_ERASE, {6'h00, 6'h1F, 12'hE00}, 0, 0);
    run(OPC_BLOCK_ERASE, {6'h00, 6'h20, 12'h000}, BC, 0);
    @(negedge i_clk);
    i_write_guard_n = 1'b1;
    // halted clock after the ready bit follows the live state
    cmd(OPC_PAGE_ERASE, {6'h00, pg, 9'h000});
    sfps_host_model_inst.desel();
    sfps_host_model_inst.sel(1'b1);
    sfps_host_model_inst.xb(OPC_STATUS, d);
    sfps_host_model_inst.xbit(1'b0, s[0]);
    chk(s[0], 0);
    n = 0;
    while (rb_pin !== 1'b1 && n < 2000) begin
      @(negedge i_clk);
      n++;
    end
    repeat (8) @(negedge i_clk);
    chk(o_so, 1);
    sfps_host_model_inst.desel();
    // reset pin aborts a running program and holds the core idle
    cmd(OPC_PROG_ERASE, {6'h00, pg, 9'h000});
    sfps_host_model_inst.desel();
    repeat (100) @(negedge i_clk);
    i_reset_n = 1'b0;
    repeat (10) @(negedge i_clk);
    chk(o_ready_busy_n_oe, 0);
    run(OPC_PAGE_ERASE, {6'h00, pg, 9'h000}, 0, 0);
    @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (8) @(negedge i_clk);
    stat(s);
    chk(s, exp_stat(1'b1, 1'b0));
    run(OPC_PAGE_ERASE, {6'h00, pg, 9'h000}, EEC, 0);
    test_done();
  end
endmodule // sfps_flash_core_bench
`default_nettype wire
